// *** srm_map.vh ***
`ifndef SRM_MAP_VH
`define SRM_MAP_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define SRM_IDX_IDENT_UPPER 7'h00
`define SRM_IDX_IDENT_LOWER 7'h01
`define SRM_IDX_PENDING 7'h02
`define SRM_IDX_MEAN_HI 7'h09
`define SRM_IDX_MEAN_LO 7'h0A
`define SRM_IDX_FRAME_TALLY 7'h0E
`define SRM_IDX_POWER_TIMING 7'h10
`define SRM_IDX_READOUT_ORDER 7'h11
`define SRM_IDX_GRAB_STROBE 7'h14
`define SRM_IDX_FLIP 7'h16
`define SRM_IDX_OUTPUT_CODING 7'h17
`define SRM_IDX_STANDBY_HOLD 7'h1C
`define SRM_IDX_OPER_STATE 7'h1D
`define SRM_IDX_FINE_HI 7'h20
`define SRM_IDX_FINE_LO 7'h21
`define SRM_IDX_COARSE_HI 7'h22
`define SRM_IDX_COARSE_LO 7'h23
`define SRM_IDX_GAIN 7'h24
`define SRM_IDX_DIVIDER 7'h25
`define SRM_IDX_OFFSET_HI 7'h2C
`define SRM_IDX_OFFSET_LO 7'h2D
`define SRM_IDX_OFFSET_EN 7'h2E
`define SRM_IDX_ROW_HI 7'h52
`define SRM_IDX_ROW_LO 7'h53
`define SRM_IDX_COL_START_HI 7'h57
`define SRM_IDX_COL_START_LO 7'h58
`define SRM_IDX_ROW_START_LO 7'h5A
`define SRM_IDX_FRAME_HI 7'h61
`define SRM_IDX_FRAME_LO 7'h62

// ----------------------------------------------------------------
// Pending flag bit positions
// ----------------------------------------------------------------
`define SRM_BIT_TIMING 7
`define SRM_BIT_ODD_EVEN 4
`define SRM_BIT_DIVIDER 3
`define SRM_BIT_GAIN 2
`define SRM_BIT_COARSE 1
`define SRM_BIT_FINE 0

// ----------------------------------------------------------------
// Reset values and soft reset bit position
// ----------------------------------------------------------------
`define SRM_RST_POWER_TIMING 8'h21
`define SRM_RST_READOUT_ORDER 8'h80
`define SRM_RST_COARSE_HI 2'h2
`define SRM_RST_COARSE_LO 8'h0A
`define SRM_RST_OPER_STATE 3'h1
`define SRM_BIT_SOFT_RESET 2

`endif

// *** srm_register_bank.v ***
`timescale 1ns/10ps
// Operation
// R1: Byte-wide registers selected by serial index.
// R2: Read-only registers ignore writes; others read/write.
// R3: Fixed 12-bit type plus 4-bit revision.
// R4: Index zero returns type bits eleven to four.
// R5: Index one: type low nibble, revision low.
// R6: Bit 7 flags unconsumed video timing parameters.
// R7: Bit 4 toggles each frame, resets one.
// R8: Bit 3 flags unconsumed clock divisor.
// R9: Bit 2 flags unconsumed gain value.
// R10: Bit 1 flags unconsumed coarse exposure.
// R11: Bit 0 flags unconsumed fine exposure.
// R12: Dark mean readback, two's complement, 11 bits.
// R13: Dark sample count limited to 256 pixels.
// R14: Frame counter starts zero, increments per frame.
// R15: Writable dark offset pair plus enable register.
// R16: Writable line period and frame period pairs.
// R17: Timed parameters taken up at next frame start.
// R18: Gain takes effect one frame after others.
// R19: Pending flags set on write, cleared on use.
// R20: Unmapped indices read zero, ignore writes.
`include "srm_map.vh"

module srm_register_bank #(
    parameter [11:0] CHIP_TYPE = 12'hABC, // Arbitrary value.
    parameter [3:0] MASK_REV = 4'h3,      // Arbitrary value.
    parameter [8:0] MAX_DARK_SAMPLES = 9'h100
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Register access from the serial engine
    input wire [6:0] reg_index,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    // Sensor timing and measurement
    input wire frame_start,
    input wire [10:0] dark_mean,
    input wire [2:0] oper_state,
    // Parameters as consumed by the exposure and video logic
    output reg [9:0] fine_active,
    output reg [9:0] coarse_active,
    output reg [3:0] gain_active,
    output reg [3:0] divider_active,
    output reg [9:0] row_period_active,
    output reg [9:0] frame_period_active,
    output reg [8:0] dark_sample_count,
    // Static configuration
    output reg [7:0] power_timing_cfg,
    output reg [7:0] readout_order_cfg,
    output reg [7:0] grab_strobe_cfg,
    output reg [7:0] flip_cfg,
    output reg [6:0] output_coding_cfg,
    output reg [1:0] standby_hold_ctrl,
    output reg [2:0] black_offset_hi,
    output reg [7:0] black_offset_lo,
    output reg [2:0] black_offset_enable,
    output reg [8:0] window_col_start,
    output reg [7:0] window_row_start_lo
);

    // ----------------------------------------------------------------
    // Host-side copies of timed parameters
    // ----------------------------------------------------------------
    reg [1:0] fine_integration_hi;
    reg [7:0] fine_integration_lo;
    reg [1:0] coarse_integration_hi;
    reg [7:0] coarse_integration_lo;
    reg [3:0] amp_gain;
    reg [3:0] pixel_rate_divider;
    reg [1:0] row_period_hi;
    reg [7:0] row_period_lo;
    reg [1:0] frame_period_hi;
    reg [7:0] frame_period_lo;
    reg [3:0] gain_staged;
    reg gain_staged_valid;
    reg pend_timing;
    reg pend_divider;
    reg pend_gain;
    reg pend_coarse;
    reg pend_fine;
    reg odd_even;
    reg [7:0] frame_tally;
    reg [10:0] mean_hold;
    reg [2:0] state_hold;
    reg [7:0] next_rdata;

    wire wr = reg_write;
    wire soft_rst = wr && reg_index == `SRM_IDX_POWER_TIMING
        && reg_wdata[`SRM_BIT_SOFT_RESET];
    wire rst = sys_rst || soft_rst;

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    function hit;
        input [6:0] idx;
        input [6:0] target;
        begin
            hit = idx == target;
        end
    endfunction

    // Fewer samples in the quarter-size modes; never above the ceiling.
    function [8:0] samples_for;
        input [2:0] mode;
        begin
            if (mode == 3'h1) begin
                samples_for = MAX_DARK_SAMPLES; // R13
            end else begin
                samples_for = {1'b0, MAX_DARK_SAMPLES[8:1]}; // R13
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Host writes
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rst) begin
            power_timing_cfg <= `SRM_RST_POWER_TIMING;
            readout_order_cfg <= `SRM_RST_READOUT_ORDER;
            grab_strobe_cfg <= 8'h00;
            flip_cfg <= 8'h00;
            output_coding_cfg <= 7'h00;
            standby_hold_ctrl <= 2'h0;
            fine_integration_hi <= 2'h0;
            fine_integration_lo <= 8'h00;
            coarse_integration_hi <= `SRM_RST_COARSE_HI;
            coarse_integration_lo <= `SRM_RST_COARSE_LO;
            amp_gain <= 4'h0;
            pixel_rate_divider <= 4'h0;
            black_offset_hi <= 3'h0;
            black_offset_lo <= 8'h00;
            black_offset_enable <= 3'h0;
            row_period_hi <= 2'h0;
            row_period_lo <= 8'h00;
            window_col_start <= 9'h000;
            window_row_start_lo <= 8'h00;
            frame_period_hi <= 2'h0;
            frame_period_lo <= 8'h00;
        end else if (wr) begin // R1 R2 R20
            if (hit(reg_index, `SRM_IDX_POWER_TIMING)) power_timing_cfg <= reg_wdata;
            if (hit(reg_index, `SRM_IDX_READOUT_ORDER)) readout_order_cfg <= reg_wdata;
            if (hit(reg_index, `SRM_IDX_GRAB_STROBE)) grab_strobe_cfg <= reg_wdata;
            if (hit(reg_index, `SRM_IDX_FLIP)) flip_cfg <= reg_wdata;
            if (hit(reg_index, `SRM_IDX_OUTPUT_CODING)) output_coding_cfg <= reg_wdata[6:0];
            if (hit(reg_index, `SRM_IDX_STANDBY_HOLD)) standby_hold_ctrl <= reg_wdata[1:0];
            if (hit(reg_index, `SRM_IDX_FINE_HI)) fine_integration_hi <= reg_wdata[1:0];
            if (hit(reg_index, `SRM_IDX_FINE_LO)) fine_integration_lo <= reg_wdata;
            if (hit(reg_index, `SRM_IDX_COARSE_HI)) coarse_integration_hi <= reg_wdata[1:0];
            if (hit(reg_index, `SRM_IDX_COARSE_LO)) coarse_integration_lo <= reg_wdata;
            if (hit(reg_index, `SRM_IDX_GAIN)) amp_gain <= reg_wdata[3:0];
            if (hit(reg_index, `SRM_IDX_DIVIDER)) pixel_rate_divider <= reg_wdata[3:0];
            if (hit(reg_index, `SRM_IDX_OFFSET_HI)) black_offset_hi <= reg_wdata[2:0]; // R15
            if (hit(reg_index, `SRM_IDX_OFFSET_LO)) black_offset_lo <= reg_wdata; // R15
            if (hit(reg_index, `SRM_IDX_OFFSET_EN)) black_offset_enable <= reg_wdata[2:0]; // R15
            if (hit(reg_index, `SRM_IDX_ROW_HI)) row_period_hi <= reg_wdata[1:0]; // R16
            if (hit(reg_index, `SRM_IDX_ROW_LO)) row_period_lo <= reg_wdata; // R16
            if (hit(reg_index, `SRM_IDX_COL_START_HI)) window_col_start[8] <= reg_wdata[0];
            if (hit(reg_index, `SRM_IDX_COL_START_LO)) window_col_start[7:0] <= reg_wdata;
            if (hit(reg_index, `SRM_IDX_ROW_START_LO)) window_row_start_lo <= reg_wdata;
            if (hit(reg_index, `SRM_IDX_FRAME_HI)) frame_period_hi <= reg_wdata[1:0]; // R16
            if (hit(reg_index, `SRM_IDX_FRAME_LO)) frame_period_lo <= reg_wdata; // R16
        end
    end

    // ----------------------------------------------------------------
    // Frame-start consumption and pending flags
    // ----------------------------------------------------------------
    // A write in the same cycle as a frame start keeps its flag set: the
    // value written now was not the one sampled, so it is still pending.
    wire w_fine = wr && (hit(reg_index, `SRM_IDX_FINE_HI) || hit(reg_index, `SRM_IDX_FINE_LO));
    wire w_coarse = wr && (hit(reg_index, `SRM_IDX_COARSE_HI)
        || hit(reg_index, `SRM_IDX_COARSE_LO));
    wire w_gain = wr && hit(reg_index, `SRM_IDX_GAIN);
    wire w_div = wr && hit(reg_index, `SRM_IDX_DIVIDER);
    wire w_timing = wr && (hit(reg_index, `SRM_IDX_ROW_HI) || hit(reg_index, `SRM_IDX_ROW_LO)
        || hit(reg_index, `SRM_IDX_FRAME_HI) || hit(reg_index, `SRM_IDX_FRAME_LO));

    always @(posedge core_clk) begin
        if (rst) begin
            fine_active <= 10'h000;
            coarse_active <= {`SRM_RST_COARSE_HI, `SRM_RST_COARSE_LO};
            gain_active <= 4'h0;
            gain_staged <= 4'h0;
            gain_staged_valid <= 1'b0;
            divider_active <= 4'h0;
            row_period_active <= 10'h000;
            frame_period_active <= 10'h000;
            dark_sample_count <= MAX_DARK_SAMPLES;
            pend_fine <= 1'b0;
            pend_coarse <= 1'b0;
            pend_gain <= 1'b0;
            pend_divider <= 1'b0;
            pend_timing <= 1'b0;
            odd_even <= 1'b1; // R7
            frame_tally <= 8'h00; // R14
        end else begin
            if (frame_start) begin
                fine_active <= {fine_integration_hi, fine_integration_lo}; // R17
                coarse_active <= {coarse_integration_hi, coarse_integration_lo}; // R17
                divider_active <= pixel_rate_divider; // R17
                row_period_active <= {row_period_hi, row_period_lo}; // R17
                frame_period_active <= {frame_period_hi, frame_period_lo}; // R17
                dark_sample_count <= samples_for(power_timing_cfg[7:5]); // R13
                // Gain goes through one extra stage, landing a frame later.
                gain_staged <= amp_gain; // R18
                gain_staged_valid <= pend_gain; // R18
                if (gain_staged_valid) gain_active <= gain_staged; // R18
                odd_even <= ~odd_even; // R7
                frame_tally <= frame_tally + 8'h01; // R14
            end
            pend_fine <= w_fine || (pend_fine && !frame_start); // R11 R19
            pend_coarse <= w_coarse || (pend_coarse && !frame_start); // R10 R19
            pend_divider <= w_div || (pend_divider && !frame_start); // R8 R19
            pend_timing <= w_timing || (pend_timing && !frame_start); // R6 R19
            // Gain stays pending until it reaches the output stage.
            pend_gain <= w_gain || (pend_gain && !(frame_start && gain_staged_valid
                && gain_staged == amp_gain)); // R9 R19
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rst) begin
            mean_hold <= 11'h000;
            state_hold <= `SRM_RST_OPER_STATE;
        end else begin
            mean_hold <= dark_mean;
            state_hold <= oper_state;
        end
    end

    always @* begin
        next_rdata = 8'h00; // R20
        case (reg_index)
            `SRM_IDX_IDENT_UPPER: next_rdata = CHIP_TYPE[11:4]; // R3 R4
            `SRM_IDX_IDENT_LOWER: next_rdata = {CHIP_TYPE[3:0], MASK_REV}; // R3 R5
            `SRM_IDX_PENDING: next_rdata = {pend_timing, 2'b00, odd_even, pend_divider,
                pend_gain, pend_coarse, pend_fine}; // R6 R7 R8 R9 R10 R11
            `SRM_IDX_MEAN_HI: next_rdata = {5'h00, mean_hold[10:8]}; // R12
            `SRM_IDX_MEAN_LO: next_rdata = mean_hold[7:0]; // R12
            `SRM_IDX_FRAME_TALLY: next_rdata = frame_tally; // R14
            `SRM_IDX_POWER_TIMING: next_rdata = power_timing_cfg;
            `SRM_IDX_READOUT_ORDER: next_rdata = readout_order_cfg;
            `SRM_IDX_GRAB_STROBE: next_rdata = grab_strobe_cfg;
            `SRM_IDX_FLIP: next_rdata = flip_cfg;
            `SRM_IDX_OUTPUT_CODING: next_rdata = {1'b0, output_coding_cfg};
            `SRM_IDX_STANDBY_HOLD: next_rdata = {6'h00, standby_hold_ctrl};
            `SRM_IDX_OPER_STATE: next_rdata = {5'h00, state_hold};
            `SRM_IDX_FINE_HI: next_rdata = {6'h00, fine_integration_hi}; // R17
            `SRM_IDX_FINE_LO: next_rdata = fine_integration_lo; // R17
            `SRM_IDX_COARSE_HI: next_rdata = {6'h00, coarse_integration_hi};
            `SRM_IDX_COARSE_LO: next_rdata = coarse_integration_lo;
            `SRM_IDX_GAIN: next_rdata = {4'h0, amp_gain};
            `SRM_IDX_DIVIDER: next_rdata = {4'h0, pixel_rate_divider};
            `SRM_IDX_OFFSET_HI: next_rdata = {5'h00, black_offset_hi};
            `SRM_IDX_OFFSET_LO: next_rdata = black_offset_lo;
            `SRM_IDX_OFFSET_EN: next_rdata = {5'h00, black_offset_enable};
            `SRM_IDX_ROW_HI: next_rdata = {6'h00, row_period_hi};
            `SRM_IDX_ROW_LO: next_rdata = row_period_lo;
            `SRM_IDX_COL_START_HI: next_rdata = {7'h00, window_col_start[8]};
            `SRM_IDX_COL_START_LO: next_rdata = window_col_start[7:0];
            `SRM_IDX_ROW_START_LO: next_rdata = window_row_start_lo;
            `SRM_IDX_FRAME_HI: next_rdata = {6'h00, frame_period_hi};
            `SRM_IDX_FRAME_LO: next_rdata = frame_period_lo;
            default: next_rdata = 8'h00; // R20
        endcase
    end

    always @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= next_rdata; // R1
        end
    end

endmodule

// *** srm_register_bank_properties.sv ***
`timescale 1ns/10ps
`include "srm_map.vh"
module srm_register_bank_checker #(
    parameter [11:0] CHIP_TYPE = 12'hABC,
    parameter [3:0] MASK_REV = 4'h3
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Register port
    input wire [6:0] reg_index,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_rdata,
    // Frame side
    input wire frame_start,
    input wire [9:0] fine_active,
    input wire [3:0] gain_active,
    input wire [8:0] dark_sample_count,
    input wire [7:0] power_timing_cfg,
    input wire [7:0] readout_order_cfg
);
    // A soft reset write restores every default, so it is kept out of the hold checks.
    wire soft_rst = reg_write && reg_index == `SRM_IDX_POWER_TIMING && reg_wdata[2];
    wire rd_ok = reg_read && !soft_rst;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_ident_upper:
        assert property (rd_ok && reg_index == 7'h00 |=> reg_rdata == CHIP_TYPE[11:4])
        else $error("ident upper read wrong");
    a_ident_lower:
        assert property (rd_ok && reg_index == 7'h01 |=> reg_rdata == {CHIP_TYPE[3:0], MASK_REV})
        else $error("ident lower read wrong");
    a_unmapped_zero:
        assert property (rd_ok && reg_index == 7'h03 |=> reg_rdata == 8'h00)
        else $error("unmapped index read not zero");
    a_rdata_holds:
        assert property (!reg_read && !soft_rst |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_fine_frame_only:
        assert property (!frame_start && !soft_rst |=> $stable(fine_active))
        else $error("fine exposure applied outside frame start");
    a_gain_frame_only:
        assert property (!frame_start && !soft_rst |=> $stable(gain_active))
        else $error("gain applied outside frame start");
    a_samples_vga:
        assert property (frame_start && !soft_rst && power_timing_cfg[7:5] == 3'b001
            |=> dark_sample_count == 9'h100)
        else $error("dark sample count not 256");
    a_samples_small:
        assert property (frame_start && !soft_rst && power_timing_cfg[7:5] != 3'b001
            |=> dark_sample_count == 9'h080)
        else $error("dark sample count not 128");
    a_samples_limit:
        assert property (dark_sample_count <= 9'h100)
        else $error("dark sample count above 256");
    a_cfg_write:
        assert property (reg_write && reg_index == 7'h11 |=> readout_order_cfg == $past(reg_wdata))
        else $error("readout order write not kept");
endmodule
bind srm_register_bank srm_register_bank_checker #(.CHIP_TYPE(CHIP_TYPE), .MASK_REV(MASK_REV))
    i_srm_register_bank_checker (.core_clk, .sys_rst, .reg_index, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .frame_start, .fine_active, .gain_active, .dark_sample_count,
    .power_timing_cfg, .readout_order_cfg);

// *** srm_sensor_model.sv ***
`timescale 1ns/10ps
module srm_sensor_model #(
    parameter [10:0] MEAN = 11'h5A3,
    parameter [2:0] STATE = 3'h4
) (
    // Clock and request
    input wire core_clk,
    input wire frame_req,
    // Sensor timing and measurement
    output reg frame_start,
    output wire [10:0] dark_mean,
    output wire [2:0] oper_state
);
    initial frame_start = 1'b0;
    // Each requested cycle gives one pulse, so a long request yields back to back frames.
    always @(posedge core_clk) begin
        frame_start <= frame_req;
    end
    assign dark_mean = MEAN;
    assign oper_state = STATE;
endmodule

// *** srm_register_bank_test.sv ***
`timescale 1ns/10ps
module srm_register_bank_test;
    localparam [11:0] CHIP = 12'h3C5; // Arbitrary value.
    localparam [3:0] REV = 4'h9; // Arbitrary value.
    localparam [10:0] MEAN = 11'h5A3;
    localparam [7*7-1:0] RO = {7'h00, 7'h01, 7'h02, 7'h09, 7'h0A, 7'h0E, 7'h1D};
    localparam [7*21-1:0] RW = {7'h11, 7'h14, 7'h16, 7'h17, 7'h1C, 7'h20, 7'h21, 7'h22,
        7'h23, 7'h24, 7'h25, 7'h2C, 7'h2D, 7'h2E, 7'h52, 7'h53, 7'h57, 7'h58, 7'h5A, 7'h61, 7'h62};
    localparam [4*21-1:0] RWW = {4'h8, 4'h8, 4'h8, 4'h7, 4'h2, 4'h2, 4'h8, 4'h2, 4'h8, 4'h4,
        4'h4, 4'h3, 4'h8, 4'h3, 4'h2, 4'h8, 4'h1, 4'h8, 4'h8, 4'h2, 4'h8};
    reg core_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [6:0] reg_index = 7'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_write = 1'b0;
    reg reg_read = 1'b0;
    reg frame_req = 1'b0;
    wire [7:0] reg_rdata;
    wire frame_start;
    wire [10:0] dark_mean;
    wire [2:0] oper_state;
    wire [9:0] fine_active, coarse_active, row_period_active, frame_period_active;
    wire [3:0] gain_active, divider_active;
    wire [8:0] dark_sample_count;
    wire [7:0] power_timing_cfg, readout_order_cfg, grab_strobe_cfg, flip_cfg;
    wire [7:0] black_offset_lo, window_row_start_lo;
    wire [6:0] output_coding_cfg;
    wire [1:0] standby_hold_ctrl;
    wire [2:0] black_offset_hi, black_offset_enable;
    wire [8:0] window_col_start;
    integer errors = 0;
    integer tests_run = 0;
    integer cycles = 0;
    integer i;
    always #12.5 core_clk = ~core_clk;
    srm_sensor_model #(.MEAN(MEAN), .STATE(3'h4)) i_srm_sensor_model (.core_clk(core_clk),
        .frame_req(frame_req), .frame_start(frame_start), .dark_mean(dark_mean),
        .oper_state(oper_state));
    srm_register_bank #(.CHIP_TYPE(CHIP), .MASK_REV(REV)) i_srm_register_bank (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_index(reg_index), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .frame_start(frame_start), .dark_mean(dark_mean), .oper_state(oper_state),
        .fine_active(fine_active), .coarse_active(coarse_active), .gain_active(gain_active),
        .divider_active(divider_active), .row_period_active(row_period_active),
        .frame_period_active(frame_period_active), .dark_sample_count(dark_sample_count),
        .power_timing_cfg(power_timing_cfg), .readout_order_cfg(readout_order_cfg),
        .grab_strobe_cfg(grab_strobe_cfg), .flip_cfg(flip_cfg),
        .output_coding_cfg(output_coding_cfg), .standby_hold_ctrl(standby_hold_ctrl),
        .black_offset_hi(black_offset_hi), .black_offset_lo(black_offset_lo),
        .black_offset_enable(black_offset_enable), .window_col_start(window_col_start),
        .window_row_start_lo(window_row_start_lo));
    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task end_sim;
        begin
            $display("errors %0d tests_run %0d", errors, tests_run);
            if (errors == 0 && tests_run > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("BAD %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // Strobes drop for a full cycle between accesses so no signal is set twice in one step.
    task wr(input [6:0] idx, input [7:0] data);
        begin
            reg_index = idx;
            reg_wdata = data;
            reg_write = 1'b1;
            @(posedge core_clk) #2;
            reg_write = 1'b0;
            @(posedge core_clk) #2;
        end
    endtask
    task rd(input [6:0] idx, input [7:0] exp);
        begin
            reg_index = idx;
            reg_read = 1'b1;
            @(posedge core_clk) #2;
            reg_read = 1'b0;
            chk($sformatf("index %h", idx), exp, reg_rdata);
            @(posedge core_clk) #2;
        end
    endtask
    task frames(input integer n);
        begin
            frame_req = 1'b1;
            repeat (n) @(posedge core_clk);
            #2;
            frame_req = 1'b0;
            repeat (2) @(posedge core_clk);
            #2;
        end
    endtask
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            end_sim;
        end
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        #2;
        sys_rst = 1'b0;
        rd(7'h10, 8'h21);
        rd(7'h11, 8'h80);
        rd(7'h22, 8'h02);
        rd(7'h23, 8'h0A);
        for (i = 0; i < 7; i = i + 1)
            wr(RO[i*7 +: 7], 8'hFF);
        wr(7'h03, 8'hFF);
        rd(7'h03, 8'h00);
        rd(7'h00, CHIP[11:4]);
        rd(7'h01, {CHIP[3:0], REV});
        rd(7'h02, 8'h10);
        rd(7'h0E, 8'h00);
        rd(7'h09, {5'h00, MEAN[10:8]});
        rd(7'h0A, MEAN[7:0]);
        rd(7'h1D, 8'h04);
        for (i = 0; i < 21; i = i + 1) begin
            wr(RW[i*7 +: 7], 8'hFF);
            rd(RW[i*7 +: 7], 8'hFF >> (8 - RWW[i*4 +: 4]));
        end
        rd(7'h02, 8'h9F);
        chk("offset", 11'h7FF, {black_offset_hi, black_offset_lo});
        chk("offset_en", 11'h007, black_offset_enable);
        chk("power", 11'h021, power_timing_cfg);
        chk("readout", 11'h0FF, readout_order_cfg);
        chk("grab", 11'h0FF, grab_strobe_cfg);
        chk("flip", 11'h0FF, flip_cfg);
        chk("coding", 11'h07F, output_coding_cfg);
        chk("standby", 11'h003, standby_hold_ctrl);
        chk("col_start", 11'h1FF, window_col_start);
        chk("row_start", 11'h0FF, window_row_start_lo);
        frames(1);
        rd(7'h02, 8'h04);
        chk("fine", 11'h3FF, fine_active);
        chk("coarse", 11'h3FF, coarse_active);
        chk("divider", 11'h00F, divider_active);
        chk("row", 11'h3FF, row_period_active);
        chk("frame", 11'h3FF, frame_period_active);
        chk("gain", 11'h000, gain_active);
        rd(7'h21, 8'hFF);
        rd(7'h0E, 8'h01);
        frames(1);
        rd(7'h02, 8'h10);
        chk("gain", 11'h00F, gain_active);
        frames(253);
        rd(7'h0E, 8'hFF);
        frames(1);
        rd(7'h0E, 8'h00);
        wr(7'h10, 8'h81);
        frames(1);
        chk("samples", 11'h080, dark_sample_count);
        wr(7'h10, 8'h21);
        frames(1);
        chk("samples", 11'h100, dark_sample_count);
        wr(7'h10, 8'h04);
        rd(7'h10, 8'h21);
        rd(7'h24, 8'h00);
        chk("readout", 11'h080, readout_order_cfg);
        chk("offset", 11'h000, {black_offset_hi, black_offset_lo});
        rd(7'h02, 8'h10);
        end_sim;
    end
endmodule
